// File: src/dioic_pkg.sv
// Constants, field positions and register map of the board interrupt controller
// Functional notes
// R1: Two software-written control registers choose which sources may raise a host request.
// R2: Each peripheral interface unit feeds two lines, port C bit 3 and bit 0.
// R3: Only counters zero and one feed interrupts; counter two is absent and unreachable.
// R4: A source reaches the host only with master enable and its own enable set.
// R5: A request is caught on a low-to-high edge of the source, never its level.
// R6: Port C bits 3 and 0 follow handshake logic, or external pins when inputs.
// R7: One master enable decides whether any request reaches the host.
// R8: Each unit splits its ports into group A and group B of twelve signals.
// R9: One 8-bit control word per unit sets the mode of both port groups.
// R10: Interval timer has 16-bit counters, each with one of six modes; only modes 0, 2 and 3 are built, the others count down as mode 0 with output held high.
// R11: Each counter has its own data port; a shared control word sets access and mode.
// R12: A cleared individual enable blocks its source whatever the master enable says.
// R13: Software sets the counter enable before raising the master enable.
// R14: A write to the clear location clears pending requests; data is ignored.
// R15: Host request is the OR of latched enabled edges, master-gated, held until cleared; the code also gates each pending bit with the mask register.
package dioic_pkg;
	localparam int unsigned NUM_UNITS = 4;
	localparam int unsigned NUM_SRC   = 10;
	localparam int unsigned CTR_W     = 16;
	// ****************************************************************
	// Register indices; byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] IDX_UNIT_CTL0 = 8'h03;
	localparam logic [7:0] IDX_UNIT_STEP = 8'h04;
	localparam logic [7:0] IDX_CTR0      = 8'h10;
	localparam logic [7:0] IDX_CTR1      = 8'h11;
	localparam logic [7:0] IDX_CTR2      = 8'h12;
	localparam logic [7:0] IDX_CTR_CFG   = 8'h13;
	localparam logic [7:0] IDX_IRQ_CTL1  = 8'h14;
	localparam logic [7:0] IDX_IRQ_CTL2  = 8'h15;
	localparam logic [7:0] IDX_IRQ_CLR   = 8'h16;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h18;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h19;
	// ****************************************************************
	// Field positions and codes
	// ****************************************************************
	localparam int unsigned BIT_CTR_SEL    = 0;
	localparam int unsigned BIT_CTR_EN     = 1;
	localparam int unsigned BIT_MASTER     = 2;
	localparam int unsigned BIT_MODE_SET   = 7;
	localparam int unsigned BIT_PCLO_IN    = 0;
	localparam int unsigned BIT_PCHI_IN    = 3;
	localparam logic [1:0]  CTR_SEL_C2     = 2'h2;
	localparam logic [1:0]  RW_LATCH       = 2'h0;
	localparam logic [1:0]  RW_LSB         = 2'h1;
	localparam logic [1:0]  RW_MSB         = 2'h2;
	localparam logic [1:0]  RW_BOTH        = 2'h3;
	localparam logic [2:0]  CMODE_TC       = 3'h0;
	localparam logic [2:0]  CMODE_RATE     = 3'h2;
	localparam logic [2:0]  CMODE_SQUARE   = 3'h3;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0]  RST_UNIT_CTL   = 8'h9b;
	localparam logic [7:0]  RST_IRQ_CTL1   = 8'h00;
	localparam logic [2:0]  RST_IRQ_CTL2   = 3'h0;
	localparam logic [9:0]  RST_IRQ_MASK   = 10'h3ff;
endpackage : dioic_pkg

// File: src/dioic_edge.sv
// Rising edge detector for the interrupt source lines
`timescale 1ns/1ps
`default_nettype none
module dioic_edge import dioic_pkg::*; #(
	parameter int unsigned W = 10
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] lvl_i,
	output logic      [W-1:0] rise_o
);
	typedef struct packed {
		logic [W-1:0] prev;
	} dioic_edge_t;
	dioic_edge_t q, d;
	always_comb begin
		d      = q;
		d.prev = lvl_i;
	end
	// Prev starts high so a line already high at reset raises nothing
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q <= '{prev: '1};
		end else begin
			q <= d;
		end
	end
	assign rise_o = lvl_i & ~q.prev; // [R5]
	a_rise_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
		(rise_o != '0) |=> ((rise_o & $past(rise_o)) == '0))
		else $error("edge pulse lasted more than one cycle");
endmodule : dioic_edge
`default_nettype wire

// File: src/dioic_ctr.sv
// One interval-timer counter with byte-wide data port
`timescale 1ns/1ps
`default_nettype none
module dioic_ctr import dioic_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       ctl_we_i,
	input  wire logic [5:0] ctl_i,
	input  wire logic       dat_we_i,
	input  wire logic       dat_re_i,
	input  wire logic [7:0] dat_i,
	output logic      [7:0] dat_o,
	output logic            out_o
);
	typedef struct packed {
		logic [CTR_W-1:0] cnt;
		logic [CTR_W-1:0] rld;
		logic [CTR_W-1:0] lat;
		logic             lat_v;
		logic [2:0]       mode;
		logic [1:0]       rw;
		logic             whi;
		logic             rhi;
		logic             run;
		logic             out;
	} dioic_ctr_t;
	dioic_ctr_t q, d;
	logic [CTR_W-1:0] rd_src;
	assign rd_src = q.lat_v ? q.lat : q.cnt;
	assign dat_o  = (q.rw == RW_MSB || (q.rw == RW_BOTH && q.rhi)) ? rd_src[15:8] : rd_src[7:0];
	assign out_o  = q.out;
	// Binary counting only; decade mode bit is accepted and ignored
	always_comb begin
		logic load;
		load = 1'b0;
		d    = q;
		if (ctl_we_i) begin
			if (ctl_i[5:4] == RW_LATCH) begin // [R11]
				d.lat   = q.cnt;
				d.lat_v = 1'b1;
			end else begin
				d.rw   = ctl_i[5:4]; // [R11]
				d.mode = ctl_i[3:1]; // [R10]
				d.run  = 1'b0;
				d.whi  = 1'b0;
				d.rhi  = 1'b0;
				d.out  = (ctl_i[3:1] != CMODE_TC);
			end
		end else if (dat_we_i) begin
			unique case (q.rw)
				RW_LSB: begin
					d.rld = {8'h00, dat_i};
					load  = 1'b1;
				end
				RW_MSB: begin
					d.rld = {dat_i, 8'h00};
					load  = 1'b1;
				end
				default: begin
					if (!q.whi) begin
						d.rld[7:0] = dat_i;
						d.whi      = 1'b1;
					end else begin
						d.rld[15:8] = dat_i;
						d.whi       = 1'b0;
						load        = 1'b1;
					end
				end
			endcase
		end else if (q.run) begin
			if (q.mode == CMODE_RATE) begin
				d.cnt = (q.cnt <= 16'h0001) ? q.rld : q.cnt - 16'h0001;
				d.out = (q.cnt != 16'h0002);
			end else if (q.mode == CMODE_SQUARE) begin
				d.cnt = (q.cnt <= 16'h0001) ? {1'b0, q.rld[15:1]} : q.cnt - 16'h0001;
				d.out = (q.cnt <= 16'h0001) ? ~q.out : q.out;
			end else begin
				d.cnt = (q.cnt != '0) ? q.cnt - 16'h0001 : q.cnt;
				d.out = q.out | (q.cnt == 16'h0001);
			end
		end
		if (load) begin
			d.cnt = d.rld;
			d.run = 1'b1;
			d.out = (q.mode != CMODE_TC);
		end
		if (dat_re_i) begin
			if (q.rw == RW_BOTH) begin
				d.rhi = ~q.rhi;
			end
			if (q.rw != RW_BOTH || q.rhi) begin
				d.lat_v = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : dioic_ctr
`default_nettype wire

// File: src/dioic_top.sv
// Board interrupt controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module dioic_top import dioic_pkg::*; #(
	parameter int unsigned AW = 8
) (
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	input  wire logic [AW-1:0]           s_axi_awaddr_i,
	input  wire logic                    s_axi_awvalid_i,
	output logic                         s_axi_awready_o,
	input  wire logic [31:0]             s_axi_wdata_i,
	input  wire logic [3:0]              s_axi_wstrb_i,
	input  wire logic                    s_axi_wvalid_i,
	output logic                         s_axi_wready_o,
	output logic      [1:0]              s_axi_bresp_o,
	output logic                         s_axi_bvalid_o,
	input  wire logic                    s_axi_bready_i,
	input  wire logic [AW-1:0]           s_axi_araddr_i,
	input  wire logic                    s_axi_arvalid_i,
	output logic                         s_axi_arready_o,
	output logic      [31:0]             s_axi_rdata_o,
	output logic      [1:0]              s_axi_rresp_o,
	output logic                         s_axi_rvalid_o,
	input  wire logic                    s_axi_rready_i,
	input  wire logic [NUM_UNITS-1:0]    porta_handshake_irq_i,
	input  wire logic [NUM_UNITS-1:0]    portb_handshake_irq_i,
	input  wire logic [NUM_UNITS-1:0]    portc_line_three_irq_i,
	input  wire logic [NUM_UNITS-1:0]    portc_line_zero_irq_i,
	output logic      [NUM_UNITS*8-1:0]  unit_ctl_o,
	output logic      [NUM_UNITS*8-1:0]  portc_latch_o,
	output logic      [1:0]              ctr_out_o,
	output logic                         irq_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                      aw_v;
		logic [7:0]                aw_a;
		logic                      w_v;
		logic [7:0]                w_d;
		logic                      w_s;
		logic                      b_v;
		logic [1:0]                b_r;
		logic                      r_v;
		logic [1:0]                r_r;
		logic [7:0]                r_d;
		logic [7:0]                en1;
		logic [2:0]                en2;
		logic [NUM_SRC-1:0]        mask;
		logic [NUM_SRC-1:0]        stat;
		logic [NUM_UNITS-1:0][7:0] ctl;
		logic [NUM_UNITS-1:0][7:0] pc;
	} dioic_top_t;
	dioic_top_t q, d;

	logic [NUM_SRC-1:0] src;
	logic [NUM_SRC-1:0] rise;
	logic [NUM_SRC-1:0] en;
	logic [7:0]         ar_a;
	logic [7:0]         ctr_dat [2];
	logic [1:0]         ctr_ctl_we;
	logic [1:0]         ctr_dat_we;
	logic [1:0]         ctr_dat_re;
	logic               wr_go;
	logic               rd_go;
	logic               master;

	// ****************************************************************
	// Source selection and enables
	// ****************************************************************
	// Pin is only trusted while the lower nibble of port C is an input
	always_comb begin
		for (int u = 0; u < NUM_UNITS; u++) begin
			src[2*u]   = q.ctl[u][BIT_PCLO_IN] ? portc_line_three_irq_i[u]
				: porta_handshake_irq_i[u]; // [R2] [R6]
			src[2*u+1] = q.ctl[u][BIT_PCLO_IN] ? portc_line_zero_irq_i[u]
				: portb_handshake_irq_i[u]; // [R2] [R6]
		end
		src[8] = ctr_out_o[0]; // [R3]
		src[9] = ctr_out_o[1]; // [R3]
	end

	assign master = q.en2[BIT_MASTER];
	assign en     = {q.en2[BIT_CTR_EN] & q.en2[BIT_CTR_SEL],
		q.en2[BIT_CTR_EN] & ~q.en2[BIT_CTR_SEL], q.en1}; // [R1] [R12]
	// Counter enable gates a live source; master gates only the request, so edges latched while it is low still raise it
	assign irq_o  = master & |(q.stat & q.mask & en); // [R4] [R7] [R15] [R13]

	dioic_edge #(
		.W(NUM_SRC)
	) u_edge (
		.clk_i (clk_i),
		.rstn_i(rstn_i),
		.lvl_i (src),
		.rise_o(rise)
	);

	// ****************************************************************
	// Counters; the third is not built
	// ****************************************************************
	assign ar_a   = {s_axi_araddr_i[7:2], 2'b00};
	assign wr_go  = q.aw_v & q.w_v & ~q.b_v;
	assign rd_go  = s_axi_arvalid_i & ~q.r_v;
	for (genvar c = 0; c < 2; c++) begin : g_ctr
		localparam logic [7:0] ADR = 8'((IDX_CTR0 + 8'(c)) * 4);
		assign ctr_ctl_we[c] = wr_go & q.w_s & (q.aw_a == 8'(IDX_CTR_CFG * 4))
			& (q.w_d[7:6] == 2'(c)); // [R11]
		assign ctr_dat_we[c] = wr_go & q.w_s & (q.aw_a == ADR); // [R11]
		assign ctr_dat_re[c] = rd_go & (ar_a == ADR);
		dioic_ctr u_ctr (
			.clk_i   (clk_i),
			.rstn_i  (rstn_i),
			.ctl_we_i(ctr_ctl_we[c]),
			.ctl_i   (q.w_d[5:0]),
			.dat_we_i(ctr_dat_we[c]),
			.dat_re_i(ctr_dat_re[c]),
			.dat_i   (q.w_d),
			.dat_o   (ctr_dat[c]),
			.out_o   (ctr_out_o[c])
		); // [R10]
	end

	// ****************************************************************
	// Register slave and interrupt status
	// ****************************************************************
	always_comb begin
		logic [NUM_SRC-1:0] clr;
		logic               hit;
		clr = '0;
		hit = 1'b0;
		d   = q;
		if (s_axi_awvalid_i && !q.aw_v && !q.b_v) begin
			d.aw_v = 1'b1;
			d.aw_a = {s_axi_awaddr_i[7:2], 2'b00};
		end
		if (s_axi_wvalid_i && !q.w_v && !q.b_v) begin
			d.w_v = 1'b1;
			d.w_d = s_axi_wdata_i[7:0];
			d.w_s = s_axi_wstrb_i[0];
		end
		if (q.b_v && s_axi_bready_i) begin
			d.b_v = 1'b0;
		end
		if (wr_go) begin
			d.aw_v = 1'b0;
			d.w_v  = 1'b0;
			d.b_v  = 1'b1;
			d.b_r  = RESP_OKAY;
			for (int u = 0; u < NUM_UNITS; u++) begin
				if (q.aw_a == 8'((IDX_UNIT_CTL0 + 8'(u) * IDX_UNIT_STEP) * 4)) begin
					hit = 1'b1;
					if (q.w_s && q.w_d[BIT_MODE_SET]) begin
						d.ctl[u] = q.w_d; // [R8] [R9]
					end else if (q.w_s) begin
						d.pc[u][q.w_d[3:1]] = q.w_d[0];
					end
				end
			end
			if (q.aw_a == 8'(IDX_IRQ_CTL1 * 4)) begin
				hit = 1'b1;
				if (q.w_s) begin
					d.en1 = q.w_d; // [R1]
				end
			end else if (q.aw_a == 8'(IDX_IRQ_CTL2 * 4)) begin
				hit = 1'b1;
				if (q.w_s) begin
					d.en2 = q.w_d[2:0]; // [R1] [R7]
				end
			end else if (q.aw_a == 8'(IDX_IRQ_CLR * 4)) begin
				hit = 1'b1;
				clr = '1; // [R14]
			end else if (q.aw_a == 8'(IDX_IRQ_MASK * 4)) begin
				hit = 1'b1;
				if (q.w_s) begin
					d.mask = {2'b00, q.w_d} | (q.mask & 10'h300);
				end
			end else if (q.aw_a == 8'(IDX_CTR_CFG * 4)) begin
				hit = (q.w_d[7:6] != CTR_SEL_C2) && (q.w_d[7:6] != 2'h3); // [R3]
			end else if (q.aw_a == 8'(IDX_CTR0 * 4) || q.aw_a == 8'(IDX_CTR1 * 4)) begin
				hit = 1'b1;
			end
			if (!hit) begin
				d.b_r = RESP_DECERR;
			end
		end
		if (q.r_v && s_axi_rready_i) begin
			d.r_v = 1'b0;
		end
		if (rd_go) begin
			d.r_v = 1'b1;
			d.r_r = RESP_OKAY;
			d.r_d = 8'h00;
			if (ar_a == 8'(IDX_IRQ_STAT * 4)) begin
				d.r_d = q.stat[7:0];
				clr   = '1;
			end else if (ar_a == 8'(IDX_IRQ_MASK * 4)) begin
				d.r_d = q.mask[7:0];
			end else if (ar_a == 8'(IDX_CTR0 * 4)) begin
				d.r_d = ctr_dat[0];
			end else if (ar_a == 8'(IDX_CTR1 * 4)) begin
				d.r_d = ctr_dat[1];
			end else if (ar_a != 8'(IDX_IRQ_CTL1 * 4) && ar_a != 8'(IDX_IRQ_CTL2 * 4)
				&& ar_a != 8'(IDX_IRQ_CLR * 4)) begin
				d.r_r = RESP_DECERR; // [R3]
			end
		end
		// Set beats clear so an edge in the clearing cycle survives
		d.stat = (q.stat & ~clr) | (rise & en); // [R5] [R12] [R15]
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q      <= '0;
			q.en1  <= RST_IRQ_CTL1;
			q.en2  <= RST_IRQ_CTL2;
			q.mask <= RST_IRQ_MASK;
			q.ctl  <= {NUM_UNITS{RST_UNIT_CTL}};
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_awready_o = ~q.aw_v & ~q.b_v;
	assign s_axi_wready_o  = ~q.w_v & ~q.b_v;
	assign s_axi_bvalid_o  = q.b_v;
	assign s_axi_bresp_o   = q.b_r;
	assign s_axi_arready_o = ~q.r_v;
	assign s_axi_rvalid_o  = q.r_v;
	assign s_axi_rresp_o   = q.r_r;
	assign s_axi_rdata_o   = {24'h000000, q.r_d};
	assign unit_ctl_o      = q.ctl;
	assign portc_latch_o   = q.pc;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_master_gates_irq: assert property (irq_o |-> q.en2[BIT_MASTER]) // [R7]
		else $error("request raised with master enable low");
	a_enable_gates_irq: assert property (irq_o |-> |(q.stat & en)) // [R4]
		else $error("request raised without an enabled pending source");
	a_blocked_source: assert property ((rise & ~en) != '0 // [R12]
		|=> ((q.stat & ~$past(q.stat) & $past(rise & ~en)) == '0))
		else $error("disabled source became pending");
	a_edge_latches: assert property ((|(rise & en)) |=> ((q.stat & $past(rise & en)) == $past(rise & en))) // [R5]
		else $error("enabled edge not latched");
	a_no_level_set: assert property (1'b1 |=> ((q.stat & ~$past(q.stat) & ~$past(rise & en)) == '0)) // [R5]
		else $error("pending bit set without an edge");
	a_pending_held: assert property ((q.stat != '0) && !wr_go && !rd_go |=> (q.stat & $past(q.stat)) == $past(q.stat)) // [R15]
		else $error("pending bit dropped without a clear");
	a_clear_write: assert property (wr_go && q.aw_a == 8'(IDX_IRQ_CLR * 4) && rise == '0 |=> q.stat == '0 ##1 !irq_o || q.stat != '0) // [R14]
		else $error("clear write left pending bits");
	a_ctr2_refused: assert property (rd_go && ar_a == 8'(IDX_CTR2 * 4) |=> q.r_v && q.r_r == RESP_DECERR) // [R3]
		else $error("third counter answered a read");
	a_ctl_word_load: assert property (wr_go && q.w_s && q.w_d[BIT_MODE_SET] && q.aw_a == 8'(IDX_UNIT_CTL0 * 4) |=> q.ctl[0] == $past(q.w_d)) // [R9]
		else $error("unit control word not stored");
	a_resp_holds: assert property (q.b_v && !s_axi_bready_i |=> q.b_v && $stable(q.b_r))
		else $error("write response dropped before taken");

	c_irq_raised: cover property (!irq_o ##1 irq_o);
	c_ext_pin_edge: cover property (q.ctl[0][BIT_PCLO_IN] && rise[0] && en[0]);
	c_counter_irq: cover property (rise[8] && en[8] ##[1:4] irq_o);
	c_set_beats_clear: cover property (wr_go && q.aw_a == 8'(IDX_IRQ_CLR * 4) && |(rise & en));
endmodule : dioic_top
`default_nettype wire

// File: tb/dioic_host.sv
// Host-side AXI4-Lite master model driving the register slave
`timescale 1ns/1ps
`default_nettype none
module dioic_host (
	input  wire logic        clk_i,
	output logic      [7:0]  awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic      [31:0] wdata_o,
	output logic      [3:0]  wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic      [7:0]  araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// ****************************************************************
	// Idle bus at time zero
	// ****************************************************************
	initial begin
		awaddr_o  = 8'h00;
		awvalid_o = 1'b0;
		wdata_o   = 32'h0;
		wstrb_o   = 4'h0;
		wvalid_o  = 1'b0;
		bready_o  = 1'b0;
		araddr_o  = 8'h00;
		arvalid_o = 1'b0;
		rready_o  = 1'b0;
	end
	// ****************************************************************
	// Bus cycles; no latency assumed, the bench watchdog cuts a hang
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		awaddr_o  <= a;
		awvalid_o <= 1'b1;
		wdata_o   <= d;
		wstrb_o   <= 4'h1;
		wvalid_o  <= 1'b1;
		// Ready waits for the response so the slave must hold it a cycle
		while (!done) begin
			@(posedge clk_i);
			if (awvalid_o && awready_i)
				awvalid_o <= 1'b0;
			if (wvalid_o && wready_i)
				wvalid_o <= 1'b0;
			if (bvalid_i && bready_o) begin
				resp = bresp_i;
				bready_o <= 1'b0;
				done = 1'b1;
			end else if (bvalid_i) begin
				bready_o <= 1'b1;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		while (!done) begin
			@(posedge clk_i);
			if (arvalid_o && arready_i)
				arvalid_o <= 1'b0;
			if (rvalid_i && rready_o) begin
				d = rdata_i;
				resp = rresp_i;
				rready_o <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
endmodule : dioic_host
`default_nettype wire

// File: tb/dioic_top_tb.sv
// Self-checking bench for the board interrupt controller
`timescale 1ns/1ps
`default_nettype none
module dioic_top_tb import dioic_pkg::*; ;
	typedef struct packed {
		logic [3:0] src;
		logic [7:0] ctl1;
		logic [2:0] ctl2;
		logic [7:0] mask;
		logic       irq;
		logic [7:0] stat;
		logic       cs;
	} dioic_row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq;
	logic [31:0] wdata, rdata, unit_ctl, pc_latch;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, ctr_out;
	logic [3:0]  pa = 4'h0, pb = 4'h0, p3 = 4'h0, p0 = 4'h0;
	int          bad_count = 0;
	int          tests_run = 0;
	// Master off, own enable off and mask off rows check the gating
	dioic_row_t rows [8] = '{
		'{4'h0, 8'h01, 3'h4, 8'hff, 1'b1, 8'h01, 1'b1},
		'{4'h1, 8'h02, 3'h4, 8'hff, 1'b1, 8'h02, 1'b1},
		'{4'h5, 8'h20, 3'h4, 8'hff, 1'b1, 8'h20, 1'b1},
		'{4'h7, 8'h80, 3'h4, 8'hff, 1'b1, 8'h80, 1'b1},
		'{4'h4, 8'h10, 3'h4, 8'hff, 1'b1, 8'h10, 1'b1},
		'{4'h2, 8'h04, 3'h0, 8'hff, 1'b0, 8'h04, 1'b1},
		'{4'h6, 8'h40, 3'h4, 8'hbf, 1'b0, 8'h40, 1'b1},
		'{4'h3, 8'h00, 3'h4, 8'hff, 1'b0, 8'h00, 1'b0}
	};
	always #5 clk = ~clk;
	dioic_top #(.AW(8)) dut (
		.clk_i(clk), .rstn_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.porta_handshake_irq_i(pa), .portb_handshake_irq_i(pb),
		.portc_line_three_irq_i(p3), .portc_line_zero_irq_i(p0),
		.unit_ctl_o(unit_ctl), .portc_latch_o(pc_latch), .ctr_out_o(ctr_out), .irq_o(irq)
	);
	dioic_host host (
		.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready)
	);
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr_chk(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		host.wr({idx[5:0], 2'h0}, d, r);
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd({idx[5:0], 2'h0}, d, r);
		chk("rresp", {30'h0, r}, {30'h0, er});
		if (er === RESP_OKAY)
			chk("rdata", d, ed);
	endtask : rd_chk
	task automatic pulse(input int s);
		@(posedge clk);
		if (s % 2 == 0)
			p3[s/2] <= 1'b1;
		else
			p0[s/2] <= 1'b1;
		repeat (2) @(posedge clk);
		p3 <= 4'h0;
		p0 <= 4'h0;
		repeat (3) @(posedge clk);
	endtask : pulse
	// ****************************************************************
	// Watchdog; the whole run needs well under 3000 cycles
	// ****************************************************************
	initial begin
		repeat (8000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("unit_ctl", unit_ctl, {4{RST_UNIT_CTL}});
		chk("pc_latch", pc_latch, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		rd_chk(IDX_IRQ_MASK, 32'hff, RESP_OKAY);
		rd_chk(IDX_IRQ_CTL1, 32'h0, RESP_OKAY);
		rd_chk(IDX_UNIT_CTL0, 32'h0, RESP_DECERR);
		foreach (rows[i]) begin
			wr_chk(IDX_IRQ_MASK, {24'h0, rows[i].mask}, RESP_OKAY);
			wr_chk(IDX_IRQ_CTL1, {24'h0, rows[i].ctl1}, RESP_OKAY);
			wr_chk(IDX_IRQ_CTL2, {29'h0, rows[i].ctl2}, RESP_OKAY);
			pulse(int'(rows[i].src));
			chk("irq", {31'h0, irq}, {31'h0, rows[i].irq});
			if (rows[i].cs)
				rd_chk(IDX_IRQ_STAT, {24'h0, rows[i].stat}, RESP_OKAY);
			wr_chk(IDX_IRQ_CLR, 32'hffffffff, RESP_OKAY);
			chk("irq", {31'h0, irq}, 32'h0);
		end
		// Level held high must not re-raise after a clear
		wr_chk(IDX_IRQ_CTL1, 32'h01, RESP_OKAY);
		@(posedge clk);
		p3[0] <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		wr_chk(IDX_IRQ_CLR, 32'h0, RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		p3[0] <= 1'b0;
		pulse(0);
		chk("irq", {31'h0, irq}, 32'h1);
		wr_chk(IDX_IRQ_CLR, 32'h0, RESP_OKAY);
		// Lower port C as output: handshake lines drive, pins ignored
		wr_chk(IDX_UNIT_CTL0, 32'h80, RESP_OKAY);
		chk("unit_ctl", unit_ctl, {{3{RST_UNIT_CTL}}, 8'h80});
		wr_chk(IDX_IRQ_CTL1, 32'h03, RESP_OKAY);
		pulse(0);
		chk("irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		pa[0] <= 1'b1;
		pb[0] <= 1'b1;
		repeat (4) @(posedge clk);
		pa <= 4'h0;
		pb <= 4'h0;
		chk("irq", {31'h0, irq}, 32'h1);
		rd_chk(IDX_IRQ_STAT, 32'h03, RESP_OKAY);
		rd_chk(IDX_IRQ_STAT, 32'h00, RESP_OKAY);
		// Port C bit set and reset through unit one control word
		wr_chk(IDX_UNIT_CTL0 + IDX_UNIT_STEP, 32'h07, RESP_OKAY);
		chk("pc_latch", pc_latch, 32'h0800);
		chk("unit_ctl", unit_ctl[15:8], {24'h0, RST_UNIT_CTL});
		wr_chk(IDX_UNIT_CTL0 + IDX_UNIT_STEP, 32'h06, RESP_OKAY);
		chk("pc_latch", pc_latch, 32'h0);
		// Third counter and unmapped places refuse
		rd_chk(IDX_CTR2, 32'h0, RESP_DECERR);
		wr_chk(IDX_CTR2, 32'h0, RESP_DECERR);
		wr_chk(IDX_CTR_CFG, 32'hb0, RESP_DECERR);
		wr_chk(IDX_IRQ_STAT, 32'h0, RESP_DECERR);
		rd_chk(8'h3f, 32'h0, RESP_DECERR);
		// Counter zero terminal count raises the host request
		wr_chk(IDX_IRQ_CTL1, 32'h0, RESP_OKAY);
		wr_chk(IDX_CTR_CFG, 32'h30, RESP_OKAY);
		wr_chk(IDX_CTR0, 32'h40, RESP_OKAY);
		wr_chk(IDX_CTR0, 32'h00, RESP_OKAY);
		chk("ctr_out", {30'h0, ctr_out}, 32'h0);
		wr_chk(IDX_IRQ_CTL2, 32'h2, RESP_OKAY);
		wr_chk(IDX_IRQ_CTL2, 32'h6, RESP_OKAY);
		for (int n = 0; n < 100 && ctr_out[0] !== 1'b1; n++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk("ctr_out", {31'h0, ctr_out[0]}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		rd_chk(IDX_IRQ_STAT, 32'h00, RESP_OKAY);
		chk("irq", {31'h0, irq}, 32'h0);
		// Counter one in rate mode feeds source nine; low pulse lasts one cycle
		wr_chk(IDX_CTR_CFG, 32'h54, RESP_OKAY);
		wr_chk(IDX_CTR1, 32'h05, RESP_OKAY);
		wr_chk(IDX_IRQ_CTL2, 32'h3, RESP_OKAY);
		wr_chk(IDX_IRQ_CTL2, 32'h7, RESP_OKAY);
		for (int n = 0; n < 20 && ctr_out[1] !== 1'b0; n++)
			@(posedge clk);
		@(posedge clk);
		chk("ctr_out", {31'h0, ctr_out[1]}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		// High byte only access reads the running count
		wr_chk(IDX_CTR_CFG, 32'h60, RESP_OKAY);
		wr_chk(IDX_CTR1, 32'h12, RESP_OKAY);
		rd_chk(IDX_CTR1, 32'h11, RESP_OKAY);
		tally_and_finish();
	end
endmodule : dioic_top_tb
`default_nettype wire
